// ===== pkg/mic_pkg.sv
package mic_pkg;
  // Register byte offsets on the AHB-Lite slave
  localparam logic [7:0] ADDR_EDGE = 8'h00;
  localparam logic [7:0] ADDR_CTRL0 = 8'h04;
  localparam logic [7:0] ADDR_CTRL1 = 8'h08;
  localparam logic [7:0] ADDR_CTRL2 = 8'h0c;
  localparam logic [7:0] ADDR_PTIMER = 8'h10;
  localparam logic [7:0] ADDR_PERIPH = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;

  // Field positions
  localparam int GIE_BIT = 0;
  localparam int PROT_EN_BIT = 1;
  localparam int EXT0_EN_BIT = 2;
  localparam int PROT_FLAG_BIT = 4;
  localparam int EXT0_FLAG_BIT = 5;
  localparam int MF2_EN_BIT = 1;
  localparam int MF3_EN_BIT = 2;
  localparam int MF2_FLAG_BIT = 5;
  localparam int MF3_FLAG_BIT = 6;
  localparam int EXT1_EN_BIT = 1;
  localparam int EXT1_FLAG_BIT = 5;
  localparam int GROUP_FLAG_LSB = 4;

  // Implemented-bit masks and reset values
  localparam logic [7:0] MASK_EDGE = 8'h0f;
  localparam logic [7:0] MASK_CTRL0 = 8'h37;
  localparam logic [7:0] MASK_CTRL1 = 8'h66;
  localparam logic [7:0] MASK_CTRL2 = 8'h22;
  localparam logic [7:0] MASK_PTIMER = 8'hff;
  localparam logic [7:0] MASK_PERIPH = 8'h77;
  localparam logic [7:0] RESET_REG = 8'h00;

  // Sources in priority order, index 0 highest
  localparam int NUM_SRC = 5;
  localparam logic [2:0] SRC_PROT = 3'h0;
  localparam logic [2:0] SRC_EXT0 = 3'h1;
  localparam logic [2:0] SRC_MF2 = 3'h2;
  localparam logic [2:0] SRC_EXT1 = 3'h3;
  localparam logic [2:0] SRC_MF3 = 3'h4;
  localparam int PC_W = 12;
  localparam logic [PC_W-1:0] VEC_TABLE [NUM_SRC] = '{12'h004, 12'h008, 12'h00c, 12'h010, 12'h014};

  typedef enum logic [1:0] {
    EDGE_OFF = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_FALL = 2'b10,
    EDGE_BOTH = 2'b11
  } mic_edge_t;

  typedef enum logic [1:0] {
    DPH_IDLE = 2'b00,
    DPH_WRITE = 2'b01,
    DPH_RWAIT = 2'b10,
    DPH_RDONE = 2'b11
  } mic_dph_t;

  typedef struct packed {
    logic push;
    logic [PC_W-1:0] pushAddr;
    logic pcLoad;
    logic [PC_W-1:0] pcAddr;
    logic pop;
  } mic_core_cmd_t;
endpackage

// ===== rtl/mic_irq_ctrl.sv
// Local design decisions: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
module mic_irq_ctrl (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic protectEvent,
  input wire logic [3:0] ptimerEvent,
  input wire logic [2:0] periphEvent,
  input wire logic [1:0] extIrqPins,
  input wire logic [1:0] pullUpSel,
  output logic [1:0] pullUpEn,
  output logic [1:0] extPinIsIrq,
  input wire logic fetchSlot,
  input wire logic [mic_pkg::PC_W-1:0] nextPc,
  input wire logic stackFull,
  input wire logic retiExec,
  output mic_pkg::mic_core_cmd_t coreCmd,
  output logic wakeReq
);

  function automatic logic [7:0] nextReg(input logic [7:0] old, input logic [7:0] mask, input logic wr,
                                         input logic [7:0] wdata, input logic [7:0] set, input logic [7:0] clr);
    logic [7:0] base;
    base = wr ? wdata : old;
    return ((base & ~clr) | set) & mask;
  endfunction

  logic [7:0] edge_q, ctrl0_q, ctrl1_q, ctrl2_q, ptimer_q, periph_q, status_q;
  logic [7:0] edge_d, ctrl0_d, ctrl1_d, ctrl2_d, ptimer_d, periph_d;
  logic [7:0] addr_q;
  mic_pkg::mic_dph_t dph_q, dph_d;
  logic [31:0] rdData_q;
  logic [1:0] pinS1_q, pinS2_q, pinS3_q;
  logic [2:0] lastWin_q;
  mic_pkg::mic_core_cmd_t coreCmd_q;
  logic wakeReq_q;
  logic [1:0] pullUpEn_q;

  // Bus address phase decode
  wire addrPhase = hsel & htrans[1] & hready;
  wire [7:0] regAddr = {haddr[7:2], 2'b00};
  wire wrPhase = (dph_q == mic_pkg::DPH_WRITE);
  wire [7:0] wData = hwdata[7:0];
  wire wrEdge = wrPhase & (addr_q == mic_pkg::ADDR_EDGE);
  wire wrCtrl0 = wrPhase & (addr_q == mic_pkg::ADDR_CTRL0);
  wire wrCtrl1 = wrPhase & (addr_q == mic_pkg::ADDR_CTRL1);
  wire wrCtrl2 = wrPhase & (addr_q == mic_pkg::ADDR_CTRL2);
  wire wrPtimer = wrPhase & (addr_q == mic_pkg::ADDR_PTIMER);
  wire wrPeriph = wrPhase & (addr_q == mic_pkg::ADDR_PERIPH);

  always_comb begin
    dph_d = mic_pkg::DPH_IDLE;
    unique case (dph_q)
      mic_pkg::DPH_RWAIT: dph_d = mic_pkg::DPH_RDONE;
      mic_pkg::DPH_IDLE, mic_pkg::DPH_WRITE, mic_pkg::DPH_RDONE: begin
        if (addrPhase) begin
          dph_d = hwrite ? mic_pkg::DPH_WRITE : mic_pkg::DPH_RWAIT;
        end
      end
    endcase
  end

  // Reads take one wait state so a write just before is always seen
  assign hreadyout = (dph_q != mic_pkg::DPH_RWAIT);
  assign hresp = 1'b0;
  assign hrdata = rdData_q;

  wire [7:0] readMux = (addr_q == mic_pkg::ADDR_EDGE) ? edge_q :
                       (addr_q == mic_pkg::ADDR_CTRL0) ? ctrl0_q :
                       (addr_q == mic_pkg::ADDR_CTRL1) ? ctrl1_q :
                       (addr_q == mic_pkg::ADDR_CTRL2) ? ctrl2_q :
                       (addr_q == mic_pkg::ADDR_PTIMER) ? ptimer_q :
                       (addr_q == mic_pkg::ADDR_PERIPH) ? periph_q :
                       (addr_q == mic_pkg::ADDR_STATUS) ? status_q : 8'h00;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dph_q <= mic_pkg::DPH_IDLE;
      addr_q <= 8'h00;
      rdData_q <= 32'h0000_0000;
    end else begin
      dph_q <= dph_d;
      if (addrPhase) begin
        addr_q <= regAddr;
      end
      if (dph_q == mic_pkg::DPH_RWAIT) begin
        rdData_q <= {24'h00_0000, readMux};
      end
    end
  end

  // External pins: two-stage synchroniser, third stage for edge detection
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pinS1_q <= 2'b00;
      pinS2_q <= 2'b00;
      pinS3_q <= 2'b00;
      pullUpEn_q <= 2'b00;
    end else begin
      pinS1_q <= extIrqPins;
      pinS2_q <= pinS1_q;
      pinS3_q <= pinS2_q;
      pullUpEn_q <= pullUpSel;
    end
  end

  wire [1:0] extEn = {ctrl2_q[mic_pkg::EXT1_EN_BIT], ctrl0_q[mic_pkg::EXT0_EN_BIT]};
  wire [1:0] pinRise = pinS2_q & ~pinS3_q;
  wire [1:0] pinFall = ~pinS2_q & pinS3_q;
  logic [1:0] extSet;
  genvar gp;
  generate
    for (gp = 0; gp < 2; gp++) begin : g_pin
      wire [1:0] sel = edge_q[2*gp +: 2];
      // pin serves as interrupt input only when enabled
      assign extPinIsIrq[gp] = extEn[gp] & (sel != mic_pkg::EDGE_OFF);
      assign extSet[gp] = extPinIsIrq[gp] & ((sel[0] & pinRise[gp]) | (sel[1] & pinFall[gp]));
    end
  endgenerate
  assign pullUpEn = pullUpEn_q;

  // Grouped source flags: a newly set flag with its enable raises the shared flag
  wire [3:0] ptimerNew = ptimerEvent & ~ptimer_q[7:4];
  wire [2:0] periphNew = periphEvent & ~periph_q[6:4];
  wire mf2Set = |(ptimerNew & ptimer_q[3:0]);
  wire mf3Set = |(periphNew & periph_q[2:0]);

  // Pending requests in priority order
  wire [mic_pkg::NUM_SRC-1:0] flags = {ctrl1_q[mic_pkg::MF3_FLAG_BIT], ctrl2_q[mic_pkg::EXT1_FLAG_BIT],
                                       ctrl1_q[mic_pkg::MF2_FLAG_BIT], ctrl0_q[mic_pkg::EXT0_FLAG_BIT],
                                       ctrl0_q[mic_pkg::PROT_FLAG_BIT]};
  wire [mic_pkg::NUM_SRC-1:0] enables = {ctrl1_q[mic_pkg::MF3_EN_BIT], ctrl2_q[mic_pkg::EXT1_EN_BIT],
                                         ctrl1_q[mic_pkg::MF2_EN_BIT], ctrl0_q[mic_pkg::EXT0_EN_BIT],
                                         ctrl0_q[mic_pkg::PROT_EN_BIT]};
  wire [mic_pkg::NUM_SRC-1:0] pending = flags & enables;
  wire anyPend = |pending;
  wire gie = ctrl0_q[mic_pkg::GIE_BIT];

  logic [2:0] winner;
  always_comb begin
    winner = 3'h0;
    for (int i = mic_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (pending[i]) begin
        winner = 3'(i);
      end
    end
  end

  // take only with global enable and room on the stack
  wire take = gie & anyPend & ~stackFull & fetchSlot;
  wire [mic_pkg::NUM_SRC-1:0] takeClr = take ? (mic_pkg::NUM_SRC'(1) << winner) : '0;

  // clears on take, applied after any software write
  wire [7:0] ctrl0Clr = {2'b00, takeClr[mic_pkg::SRC_EXT0], takeClr[mic_pkg::SRC_PROT], 3'b000, take};
  wire [7:0] ctrl1Clr = {1'b0, takeClr[mic_pkg::SRC_MF3], takeClr[mic_pkg::SRC_MF2], 5'b00000};
  wire [7:0] ctrl2Clr = {2'b00, takeClr[mic_pkg::SRC_EXT1], 5'b00000};
  wire [7:0] ctrl0Set = {2'b00, extSet[0], protectEvent, 4'h0};
  wire [7:0] ctrl1Set = {1'b0, mf3Set, mf2Set, 5'b00000};
  wire [7:0] ctrl2Set = {2'b00, extSet[1], 5'b00000};
  wire [7:0] ptimerSet = {ptimerEvent, 4'h0};
  wire [7:0] periphSet = {1'b0, periphEvent, 4'h0};

  // software write, then take clear, then hardware set
  assign edge_d = nextReg(edge_q, mic_pkg::MASK_EDGE, wrEdge, wData, 8'h00, 8'h00);
  assign ctrl0_d = nextReg(ctrl0_q, mic_pkg::MASK_CTRL0, wrCtrl0, wData, ctrl0Set, ctrl0Clr);
  assign ctrl1_d = nextReg(ctrl1_q, mic_pkg::MASK_CTRL1, wrCtrl1, wData, ctrl1Set, ctrl1Clr);
  assign ctrl2_d = nextReg(ctrl2_q, mic_pkg::MASK_CTRL2, wrCtrl2, wData, ctrl2Set, ctrl2Clr);
  // grouped source flags change only by event or software
  assign ptimer_d = nextReg(ptimer_q, mic_pkg::MASK_PTIMER, wrPtimer, wData, ptimerSet, 8'h00);
  assign periph_d = nextReg(periph_q, mic_pkg::MASK_PERIPH, wrPeriph, wData, periphSet, 8'h00);

  // wake only on a flag going from clear to set by hardware
  wire [7:0] flagMask = 8'hf0;
  wire newFlag = |((ctrl0Set & ~ctrl0_q) | (ctrl1Set & ~ctrl1_q) | (ctrl2Set & ~ctrl2_q) |
                   (ptimerSet & ~ptimer_q) | (periphSet & ~periph_q) & flagMask);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      edge_q <= mic_pkg::RESET_REG;
      ctrl0_q <= mic_pkg::RESET_REG;
      ctrl1_q <= mic_pkg::RESET_REG;
      ctrl2_q <= mic_pkg::RESET_REG;
      ptimer_q <= mic_pkg::RESET_REG;
      periph_q <= mic_pkg::RESET_REG;
    end else begin
      edge_q <= edge_d;
      ctrl0_q <= ctrl0_d;
      ctrl1_q <= ctrl1_d;
      ctrl2_q <= ctrl2_d;
      ptimer_q <= ptimer_d;
      periph_q <= periph_d;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      coreCmd_q <= '0;
      lastWin_q <= 3'h0;
      wakeReq_q <= 1'b0;
      status_q <= 8'h00;
    end else begin
      // push next address and load vector
      coreCmd_q.push <= take;
      coreCmd_q.pcLoad <= take;
      coreCmd_q.pop <= retiExec;
      if (take) begin
        coreCmd_q.pushAddr <= nextPc;
        coreCmd_q.pcAddr <= mic_pkg::VEC_TABLE[winner];
        lastWin_q <= winner;
      end
      wakeReq_q <= newFlag;
      status_q <= {3'b000, anyPend, stackFull, (take ? winner : lastWin_q)};
    end
  end

  assign coreCmd = coreCmd_q;
  assign wakeReq = wakeReq_q;

  // Assertions
  a_gie_cleared_take:
    assert property (@(posedge clk) disable iff (!reset_n) take |=> !ctrl0_q[mic_pkg::GIE_BIT])
    else $error("global enable not cleared after take");
  a_gie_off_block:
    assert property (@(posedge clk) disable iff (!reset_n) !gie |-> ##1 !coreCmd.pcLoad)
    else $error("vector loaded while global enable off");
  a_stack_full_hold:
    assert property (@(posedge clk) disable iff (!reset_n)
      stackFull && anyPend && !wrPhase |=> !coreCmd.push && anyPend)
    else $error("take while stack full or request lost");
  a_push_vector_pair:
    assert property (@(posedge clk) disable iff (!reset_n)
      take |=> coreCmd.push && coreCmd.pcLoad && coreCmd.pushAddr == $past(nextPc))
    else $error("push or vector load missing after take");
  a_return_pop:
    assert property (@(posedge clk) disable iff (!reset_n) $rose(retiExec) |=> coreCmd.pop ##1 !$past(retiExec) || coreCmd.pop)
    else $error("pop not issued on return");
  a_event_sets_flag:
    assert property (@(posedge clk) disable iff (!reset_n) protectEvent |=> ctrl0_q[mic_pkg::PROT_FLAG_BIT])
    else $error("protection event did not set flag");
  a_ext_flag_clear:
    assert property (@(posedge clk) disable iff (!reset_n)
      take && winner == mic_pkg::SRC_EXT0 && !extSet[0] |=> !ctrl0_q[mic_pkg::EXT0_FLAG_BIT])
    else $error("external flag not cleared on service");
  a_blocked_flag_kept:
    assert property (@(posedge clk) disable iff (!reset_n)
      !gie && ptimer_q[7] && !wrPtimer |=> ptimer_q[7])
    else $error("request flag lost while blocked");
  a_enabled_only:
    assert property (@(posedge clk) disable iff (!reset_n) take |-> pending[winner] && enables[winner])
    else $error("take of a disabled source");
  a_top_priority:
    assert property (@(posedge clk) disable iff (!reset_n)
      take && pending[mic_pkg::SRC_PROT] |=> coreCmd.pcAddr == mic_pkg::VEC_TABLE[mic_pkg::SRC_PROT])
    else $error("highest priority source not served");
  a_rise_sets_ext:
    assert property (@(posedge clk) disable iff (!reset_n)
      ctrl0_q[mic_pkg::EXT0_EN_BIT] && edge_q[1:0] == mic_pkg::EDGE_RISE && pinS2_q[0] && !pinS3_q[0]
      |=> ctrl0_q[mic_pkg::EXT0_FLAG_BIT] || $past(take))
    else $error("rising edge missed on pin 0");
  a_preset_no_wake:
    assert property (@(posedge clk) disable iff (!reset_n)
      ptimer_q[7] && ptimerEvent == 4'h8 && !protectEvent && periphEvent == 3'h0 && extSet == 2'b00
      && !mf2Set && !mf3Set |=> !wakeReq)
    else $error("wake from an already set flag");
  a_read_wait:
    assert property (@(posedge clk) disable iff (!reset_n) addrPhase && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");

  // Flag set and clear paths, vector selection, register write, wake and pop
  a_fall_sets_ext:
    assert property (@(posedge clk) disable iff (!reset_n)
      ctrl0_q[mic_pkg::EXT0_EN_BIT] && edge_q[1:0] == mic_pkg::EDGE_FALL && !pinS2_q[0] && pinS3_q[0]
      |=> ctrl0_q[mic_pkg::EXT0_FLAG_BIT])
    else $error("falling edge missed on pin 0");
  a_both_sets_ext:
    assert property (@(posedge clk) disable iff (!reset_n)
      ctrl0_q[mic_pkg::EXT0_EN_BIT] && edge_q[1:0] == mic_pkg::EDGE_BOTH && pinS2_q[0] != pinS3_q[0]
      |=> ctrl0_q[mic_pkg::EXT0_FLAG_BIT])
    else $error("dual edge missed on pin 0");
  a_edge_off_quiet:
    assert property (@(posedge clk) disable iff (!reset_n)
      edge_q[1:0] == mic_pkg::EDGE_OFF && !ctrl0_q[mic_pkg::EXT0_FLAG_BIT] && !wrCtrl0
      |=> !ctrl0_q[mic_pkg::EXT0_FLAG_BIT])
    else $error("pin 0 flag set with edge select off");
  a_pin1_needs_enable:
    assert property (@(posedge clk) disable iff (!reset_n)
      !ctrl2_q[mic_pkg::EXT1_EN_BIT] && !ctrl2_q[mic_pkg::EXT1_FLAG_BIT] && !wrCtrl2
      |=> !ctrl2_q[mic_pkg::EXT1_FLAG_BIT])
    else $error("pin 1 flag set while pin not enabled");
  a_rise_sets_ext1:
    assert property (@(posedge clk) disable iff (!reset_n)
      ctrl2_q[mic_pkg::EXT1_EN_BIT] && edge_q[3:2] == mic_pkg::EDGE_RISE && pinS2_q[1] && !pinS3_q[1]
      |=> ctrl2_q[mic_pkg::EXT1_FLAG_BIT])
    else $error("rising edge missed on pin 1");
  a_blocked_prot_kept:
    assert property (@(posedge clk) disable iff (!reset_n)
      !gie && ctrl0_q[mic_pkg::PROT_FLAG_BIT] && !wrCtrl0 |=> ctrl0_q[mic_pkg::PROT_FLAG_BIT])
    else $error("protection flag lost while blocked");
  a_prot_flag_clear:
    assert property (@(posedge clk) disable iff (!reset_n)
      take && winner == mic_pkg::SRC_PROT && !protectEvent |=> !ctrl0_q[mic_pkg::PROT_FLAG_BIT])
    else $error("protection flag not cleared on service");
  a_prot_needs_enable:
    assert property (@(posedge clk) disable iff (!reset_n)
      take && !ctrl0_q[mic_pkg::PROT_EN_BIT] |=> coreCmd.pcAddr != mic_pkg::VEC_TABLE[mic_pkg::SRC_PROT])
    else $error("protection vector taken while disabled");
  a_shared_set:
    assert property (@(posedge clk) disable iff (!reset_n) mf2Set |=> ctrl1_q[mic_pkg::MF2_FLAG_BIT])
    else $error("shared flag not set by grouped source");
  a_shared_clear:
    assert property (@(posedge clk) disable iff (!reset_n)
      take && winner == mic_pkg::SRC_MF3 && !mf3Set |=> !ctrl1_q[mic_pkg::MF3_FLAG_BIT])
    else $error("shared flag not cleared on service");
  a_source_flag_kept:
    assert property (@(posedge clk) disable iff (!reset_n)
      take && ptimer_q[4] && !wrPtimer |=> ptimer_q[4])
    else $error("grouped source flag cleared by service");
  a_shared_vector:
    assert property (@(posedge clk) disable iff (!reset_n)
      take && winner == mic_pkg::SRC_MF2 |=> coreCmd.pcAddr == mic_pkg::VEC_TABLE[mic_pkg::SRC_MF2])
    else $error("shared vector address wrong");
  a_sw_write_lands:
    assert property (@(posedge clk) disable iff (!reset_n)
      wrPtimer && ptimerEvent == 4'h0 |=> ptimer_q == $past(hwdata[7:0]))
    else $error("software write to timer register lost");
  a_new_flag_wakes:
    assert property (@(posedge clk) disable iff (!reset_n)
      protectEvent && !ctrl0_q[mic_pkg::PROT_FLAG_BIT] |=> wakeReq)
    else $error("no wake on a newly set flag");
  a_pop_follows:
    assert property (@(posedge clk) disable iff (!reset_n) retiExec |=> coreCmd.pop)
    else $error("pop missing after return");

endmodule // mic_irq_ctrl

// ===== testbench/mic_core_model.sv
`timescale 1ns/1ps
module mic_core_model #(parameter int DEPTH = 8) (
  input wire logic clk,
  input wire logic reset_n,
  input mic_pkg::mic_core_cmd_t coreCmd,
  input wire logic holdFull,
  input wire logic slowFetch,
  input wire logic retiReq,
  output logic fetchSlot,
  output logic [mic_pkg::PC_W-1:0] nextPc,
  output logic stackFull,
  output logic retiExec,
  output int takes,
  output logic [mic_pkg::PC_W-1:0] pcAtTake,
  output logic [mic_pkg::PC_W-1:0] popPc
);
  logic [mic_pkg::PC_W-1:0] stk [DEPTH];
  logic [mic_pkg::PC_W-1:0] prevPc;
  int sp;
  assign stackFull = holdFull || sp == DEPTH;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fetchSlot <= 1'b0;
      nextPc <= 12'h100;
      prevPc <= 12'h000;
      retiExec <= 1'b0;
      takes <= 0;
      sp <= 0;
      pcAtTake <= 12'h000;
      popPc <= 12'h000;
    end else begin
      fetchSlot <= slowFetch ? ~fetchSlot : 1'b1;
      nextPc <= nextPc + 12'h001;
      prevPc <= nextPc;
      retiExec <= retiReq;
      if (coreCmd.push) begin
        stk[sp] <= coreCmd.pushAddr;
        sp <= sp + 1;
        takes <= takes + 1;
        pcAtTake <= prevPc;
        nextPc <= coreCmd.pcAddr;
      end
      if (coreCmd.pop && sp > 0) begin
        sp <= sp - 1;
        popPc <= stk[sp-1];
        nextPc <= stk[sp-1];
      end
    end
  end
endmodule // mic_core_model

// ===== testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic clk, reset_n, hsel, hwrite, hready, hreadyout, hresp, protectEvent;
  logic fetchSlot, stackFull, retiExec, wakeReq, holdFull, slowFetch, retiReq;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans, extIrqPins, pullUpSel, pullUpEn, extPinIsIrq;
  logic [2:0] hsize, periphEvent;
  logic [3:0] ptimerEvent;
  logic [11:0] nextPc, pcAtTake, popPc, firstPush;
  mic_pkg::mic_core_cmd_t coreCmd;
  int takes;
  int fail_count = 0;
  int tests_run = 0;
  int wakes = 0;
  int cycles = 0;
  assign hready = hreadyout;

  mic_irq_ctrl u_dut (.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .protectEvent(protectEvent), .ptimerEvent(ptimerEvent),
    .periphEvent(periphEvent), .extIrqPins(extIrqPins), .pullUpSel(pullUpSel), .pullUpEn(pullUpEn),
    .extPinIsIrq(extPinIsIrq), .fetchSlot(fetchSlot), .nextPc(nextPc), .stackFull(stackFull),
    .retiExec(retiExec), .coreCmd(coreCmd), .wakeReq(wakeReq));
  mic_core_model u_core (.clk(clk), .reset_n(reset_n), .coreCmd(coreCmd), .holdFull(holdFull),
    .slowFetch(slowFetch), .retiReq(retiReq), .fetchSlot(fetchSlot), .nextPc(nextPc),
    .stackFull(stackFull), .retiExec(retiExec), .takes(takes), .pcAtTake(pcAtTake), .popPc(popPc));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task final_report;
    if (fail_count == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (wakeReq === 1'b1) wakes <= wakes + 1;
    if (cycles == 20000) begin
      fail_count = fail_count + 1;
      final_report;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    tests_run = tests_run + 1;
    if (seen !== want) begin
      fail_count = fail_count + 1;
      $display("unexpected at %0t: got %h want %h", $time, seen, want);
    end
  endtask

  // One single AHB-Lite transfer; hready and read data are taken at the rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] r);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    do @(posedge clk); while (hready !== 1'b1);
    r = hrdata;
  endtask

  // Returns once the written value has settled in the register
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
    @(negedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] r;
    bus(1'b0, a, 8'h00, r);
    chk(r, {24'h0, e});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic waitTake(input int n);
    repeat (30) if (takes < n) @(posedge clk);
    @(negedge clk);
    chk(32'(takes), 32'(n));
  endtask

  task automatic return_from_handler_instr;
    @(posedge clk) retiReq <= 1'b1;
    @(posedge clk) retiReq <= 1'b0;
    cyc(3);
  endtask

  initial begin
    logic [7:0] a, en;
    logic [1:0] code;
    int w0;
    reset_n = 1'b0;
    {hsel, hwrite, protectEvent, holdFull, slowFetch, retiReq} = '0;
    {haddr, hwdata, htrans, extIrqPins, periphEvent, ptimerEvent} = '0;
    hsize = 3'h2;
    pullUpSel = 2'b01;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 8; i++) rd(8'(i * 4), 8'h00);
    chk(32'(hresp), 32'h0);
    chk(32'(pullUpEn), 32'h1);
    wr(mic_pkg::ADDR_EDGE, 8'hff);
    rd(mic_pkg::ADDR_EDGE, mic_pkg::MASK_EDGE);
    chk(32'(extPinIsIrq), 32'h0);
    wr(mic_pkg::ADDR_CTRL2, 8'h02);
    chk(32'(extPinIsIrq), 32'h2);
    wr(mic_pkg::ADDR_PTIMER, 8'hff);
    rd(mic_pkg::ADDR_PTIMER, 8'hff);
    wr(mic_pkg::ADDR_PERIPH, 8'hff);
    rd(mic_pkg::ADDR_PERIPH, 8'h77);
    wr(mic_pkg::ADDR_PTIMER, 8'h00);
    wr(mic_pkg::ADDR_PERIPH, 8'h00);
    wr(mic_pkg::ADDR_CTRL2, 8'h00);
    wr(mic_pkg::ADDR_EDGE, 8'h00);
    // Protection source: flag, enables, take, return
    @(posedge clk) protectEvent <= 1'b1;
    @(posedge clk) protectEvent <= 1'b0;
    cyc(3);
    chk(32'(wakes), 32'h1);
    rd(mic_pkg::ADDR_CTRL0, 8'h10);
    wr(mic_pkg::ADDR_CTRL0, 8'h12);
    @(posedge clk) protectEvent <= 1'b1;
    @(posedge clk) protectEvent <= 1'b0;
    cyc(4);
    chk(32'(takes), 32'h0);
    chk(32'(wakes), 32'h1);
    wr(mic_pkg::ADDR_CTRL0, 8'h13);
    waitTake(1);
    chk(32'(coreCmd.pcAddr), 32'(mic_pkg::VEC_TABLE[mic_pkg::SRC_PROT]));
    chk(32'(coreCmd.pushAddr), 32'(pcAtTake));
    rd(mic_pkg::ADDR_CTRL0, 8'h02);
    firstPush = coreCmd.pushAddr;
    wr(mic_pkg::ADDR_CTRL0, 8'h11);
    cyc(4);
    chk(32'(takes), 32'h1);
    return_from_handler_instr;
    chk(32'(popPc), 32'(firstPush));
    // Full stack holds the request back
    holdFull <= 1'b1;
    wr(mic_pkg::ADDR_CTRL0, 8'h13);
    cyc(6);
    chk(32'(takes), 32'h1);
    rd(mic_pkg::ADDR_CTRL0, 8'h13);
    rd(mic_pkg::ADDR_STATUS, 8'h18);
    holdFull <= 1'b0;
    waitTake(2);
    return_from_handler_instr;
    // Priority with a slow core, then nesting from inside the handler
    slowFetch <= 1'b1;
    wr(mic_pkg::ADDR_CTRL0, 8'h37);
    waitTake(3);
    chk(32'(coreCmd.pcAddr), 32'(mic_pkg::VEC_TABLE[mic_pkg::SRC_PROT]));
    firstPush = coreCmd.pushAddr;
    rd(mic_pkg::ADDR_CTRL0, 8'h26);
    wr(mic_pkg::ADDR_CTRL0, 8'h27);
    waitTake(4);
    chk(32'(coreCmd.pcAddr), 32'(mic_pkg::VEC_TABLE[mic_pkg::SRC_EXT0]));
    rd(mic_pkg::ADDR_CTRL0, 8'h06);
    return_from_handler_instr;
    return_from_handler_instr;
    chk(32'(popPc), 32'(firstPush));
    slowFetch <= 1'b0;
    // Edge selection on both pins, every code
    wr(mic_pkg::ADDR_CTRL0, 8'h04);
    wr(mic_pkg::ADDR_CTRL2, 8'h02);
    for (int p = 0; p < 2; p++) begin
      for (int c = 0; c < 4; c++) begin
        a = (p == 1) ? mic_pkg::ADDR_CTRL2 : mic_pkg::ADDR_CTRL0;
        en = (p == 1) ? 8'h02 : 8'h04;
        code = 2'(c);
        wr(mic_pkg::ADDR_EDGE, 8'(code) << (2 * p));
        chk(32'(extPinIsIrq[p]), 32'(code != 2'b00));
        @(posedge clk) extIrqPins[p] <= 1'b1;
        cyc(5);
        rd(a, en | (code[0] ? 8'h20 : 8'h00));
        wr(a, en);
        @(posedge clk) extIrqPins[p] <= 1'b0;
        cyc(5);
        rd(a, en | (code[1] ? 8'h20 : 8'h00));
        wr(a, en);
      end
    end
    chk(32'(pullUpEn), 32'h1);
    wr(mic_pkg::ADDR_EDGE, 8'h00);
    wr(mic_pkg::ADDR_CTRL2, 8'h00);
    // Shared vectors for timer and peripheral groups
    wr(mic_pkg::ADDR_CTRL0, 8'h00);
    wr(mic_pkg::ADDR_PTIMER, 8'h01);
    wr(mic_pkg::ADDR_CTRL1, 8'h02);
    @(posedge clk) ptimerEvent <= 4'h1;
    @(posedge clk) ptimerEvent <= 4'h0;
    cyc(3);
    rd(mic_pkg::ADDR_CTRL1, 8'h22);
    wr(mic_pkg::ADDR_CTRL0, 8'h01);
    waitTake(5);
    chk(32'(coreCmd.pcAddr), 32'(mic_pkg::VEC_TABLE[mic_pkg::SRC_MF2]));
    rd(mic_pkg::ADDR_CTRL1, 8'h02);
    rd(mic_pkg::ADDR_PTIMER, 8'h11);
    wr(mic_pkg::ADDR_PTIMER, 8'h01);
    // Preset flag: a repeat event must not wake
    wr(mic_pkg::ADDR_PTIMER, 8'h81);
    w0 = wakes;
    @(posedge clk) ptimerEvent <= 4'h8;
    @(posedge clk) ptimerEvent <= 4'h0;
    cyc(3);
    chk(32'(wakes), 32'(w0));
    wr(mic_pkg::ADDR_PTIMER, 8'h01);
    return_from_handler_instr;
    wr(mic_pkg::ADDR_PERIPH, 8'h04);
    wr(mic_pkg::ADDR_CTRL1, 8'h04);
    @(posedge clk) periphEvent <= 3'h4;
    @(posedge clk) periphEvent <= 3'h0;
    cyc(3);
    wr(mic_pkg::ADDR_CTRL0, 8'h01);
    waitTake(6);
    chk(32'(coreCmd.pcAddr), 32'(mic_pkg::VEC_TABLE[mic_pkg::SRC_MF3]));
    rd(mic_pkg::ADDR_PERIPH, 8'h44);
    wr(mic_pkg::ADDR_PERIPH, 8'h04);
    return_from_handler_instr;
    final_report;
  end
endmodule // testbench
